// ---- include/fwp_pkg.sv ----
// Package for the flash write protection and programming control block
// Notes on behaviour
// - Type 05 sector CRC, 06 global CRC, 08 reset
// - Type 07 loads two bytes as baud timer
// - Address field ignored for types 05 to 08
// - One entry routine; function chosen by registers
// - Caller puts key 96H in RAM byte FFH
// - Key cleared after each processed call
// - Keyed call without key resets the device
// - Write enable gates serial and application writes only
// - Activate bit low forces write enable set
// - Activate bit high: software owns write enable
// - Command 08H then key 96H sets enable
// - Command 0BH then key clears enable; reset clears
// - Serial sets enable; application clears after writes
// - Protect bit refuses config writes in serial/application
// - Protect set by status byte, cleared by command
// - Disable bit blocks clear except in-circuit/parallel modes
// - Checksum checked; send X or dot; execute on match
package fwp_pkg;
  localparam logic [7:0] FWP_KEY = 8'h96;
  localparam logic [7:0] FWP_CMD_SET_WE = 8'h08;
  localparam logic [7:0] FWP_CMD_CLR_WE = 8'h0b;
  localparam logic [7:0] FWP_REC_SECT_CRC = 8'h05;
  localparam logic [7:0] FWP_REC_GLOB_CRC = 8'h06;
  localparam logic [7:0] FWP_REC_BAUD = 8'h07;
  localparam logic [7:0] FWP_REC_RESET = 8'h08;
  localparam logic [7:0] FWP_REC_MWRITE = 8'h02;
  localparam logic [7:0] FWP_SUB_CCP = 8'h10;
  localparam logic [7:0] FWP_SUB_STATUS = 8'h03;
  localparam logic [7:0] FWP_CH_BAD = 8'h58;
  localparam logic [7:0] FWP_CH_GOOD = 8'h2e;
  localparam int FWP_BIT_AWE = 7;
  localparam int FWP_BIT_CWP = 6;
  // Register byte addresses (word aligned)
  localparam logic [7:0] FWP_A_CMD = 8'h00;
  localparam logic [7:0] FWP_A_DATA = 8'h04;
  localparam logic [7:0] FWP_A_STAT = 8'h08;
  localparam logic [7:0] FWP_A_IRQ_ST = 8'h0c;
  localparam logic [7:0] FWP_A_IRQ_MSK = 8'h10;
  localparam logic [7:0] FWP_A_BAUD = 8'h14;
  localparam logic [7:0] FWP_A_IAP = 8'h18;
  localparam logic [7:0] FWP_A_BOOT = 8'h1c;
  localparam logic [7:0] FWP_RST_BOOT = 8'h00;
  localparam logic [15:0] FWP_RST_BAUD = 16'h0000;
  // Interrupt status bit positions
  localparam int FWP_EV_REC = 0;
  localparam int FWP_EV_BADSUM = 1;
  localparam int FWP_EV_NOKEY = 2;
  localparam int FWP_EV_REFUSED = 3;
  typedef enum logic [1:0] {FWP_M_ISP = 2'b00, FWP_M_IAP = 2'b01,
    FWP_M_ICP = 2'b11, FWP_M_PAR = 2'b10} fwp_mode_t;
  typedef enum logic [1:0] {FWP_S_IDLE = 2'b00, FWP_S_CMD = 2'b01} fwp_seq_t;
  typedef struct packed {
    logic valid;
    logic [7:0] rtype;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
    logic sum_ok;
  } fwp_rec_t;
  typedef struct packed {
    logic [7:0] func;
    logic [7:0] arg;
    logic [7:0] data;
    logic [7:0] key_ram;
    logic call;
  } fwp_iap_t;
endpackage

// ---- logic/fwp_top.sv ----
// Flash write enable, configuration protection and programming command logic
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module fwp_top
  import fwp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] mode_i,
  input wire fwp_rec_t rec_i,
  input wire logic [15:0] sect_crc_i,
  input wire logic [15:0] glob_crc_i,
  output logic tx_valid_o,
  output logic [7:0] tx_char_o,
  output logic mcu_reset_o,
  output logic crc_req_o,
  output logic crc_global_o,
  output logic [7:0] crc_sector_o,
  output logic [15:0] baud_o,
  output logic we_flag_o,
  output logic flash_write_ok_o,
  output logic cfg_write_ok_o,
  output logic key_clear_o,
  output logic irq_o
);
  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    fwp_seq_t seq;
    logic [7:0] cmd;
    logic we;
    logic [7:0] boot;
    logic [15:0] baud;
    logic [7:0] iap_func;
    logic [7:0] iap_arg;
    logic [7:0] iap_data;
    logic [7:0] key;
    logic tx_v;
    logic [7:0] tx_c;
    logic rst_req;
    logic crc_req;
    logic crc_glob;
    logic [7:0] crc_sect;
    logic key_clr;
    logic [3:0] ist;
    logic [3:0] imsk;
    logic fw_ok;
    logic cw_ok;
    logic irq;
  } fwp_state_t;

  fwp_state_t st_ff;
  fwp_state_t nxt_st;

  function automatic logic prot_mode(input logic [1:0] m);
    return (m == FWP_M_ISP) || (m == FWP_M_IAP);
  endfunction

  logic wr;
  logic rd;
  logic write_enable_activate;
  logic config_write_protect;
  logic we_eff;
  logic prot;
  logic [3:0] ev;
  logic ccp_ok;

  always_comb begin
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack && wb_sel_i[0];
    rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st_ff.ack;
    write_enable_activate = st_ff.boot[FWP_BIT_AWE];
    config_write_protect = st_ff.boot[FWP_BIT_CWP];
    prot = prot_mode(mode_i);
    we_eff = !write_enable_activate || st_ff.we;
    ccp_ok = !prot || !write_enable_activate;
  end

  always_comb begin
    nxt_st = st_ff;
    ev = 4'h0;
    nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
    nxt_st.tx_v = 1'b0;
    nxt_st.rst_req = 1'b0;
    nxt_st.crc_req = 1'b0;
    nxt_st.key_clr = 1'b0;
    // Command then key sequence on the flash registers
    if (wr && wb_adr_i == FWP_A_CMD) begin
      nxt_st.cmd = wb_dat_i[7:0];
      nxt_st.seq = FWP_S_CMD;
    end else if (wr && wb_adr_i == FWP_A_DATA) begin
      nxt_st.seq = FWP_S_IDLE;
      if (st_ff.seq == FWP_S_CMD && wb_dat_i[7:0] == FWP_KEY) begin
        if (st_ff.cmd == FWP_CMD_SET_WE) begin
          nxt_st.we = 1'b1;
        end else if (st_ff.cmd == FWP_CMD_CLR_WE) begin
          nxt_st.we = 1'b0;
        end
      end
    end
    if (wr && wb_adr_i == FWP_A_BOOT) begin
      if (!prot || (we_eff && !config_write_protect)) begin
        nxt_st.boot = wb_dat_i[7:0];
      end else begin
        ev[FWP_EV_REFUSED] = 1'b1;
      end
    end
    if (wr && wb_adr_i == FWP_A_BAUD) begin
      nxt_st.baud = wb_dat_i[15:0];
    end
    // Entry routine: function, argument, data and key RAM byte
    if (wr && wb_adr_i == FWP_A_IAP) begin
      nxt_st.iap_func = wb_dat_i[7:0];
      nxt_st.iap_arg = wb_dat_i[15:8];
      nxt_st.iap_data = wb_dat_i[23:16];
      nxt_st.key = wb_dat_i[31:24];
      if (wb_dat_i[7:0] == FWP_REC_MWRITE || wb_dat_i[7:0] == 8'h00
          || wb_dat_i[7:0] == 8'h04) begin
        if (wb_dat_i[31:24] != FWP_KEY) begin
          nxt_st.rst_req = 1'b1;
          ev[FWP_EV_NOKEY] = 1'b1;
        end else if (wb_dat_i[7:0] == FWP_REC_MWRITE) begin
          if (wb_dat_i[15:8] == FWP_SUB_CCP) begin
            if (ccp_ok) begin
              nxt_st.boot[FWP_BIT_CWP] = 1'b0;
              if (!prot) begin
                nxt_st.boot[FWP_BIT_AWE] = 1'b0;
              end
            end else begin
              ev[FWP_EV_REFUSED] = 1'b1;
            end
          end else if (wb_dat_i[15:8] == FWP_SUB_STATUS) begin
            if (we_eff && !config_write_protect) begin
              nxt_st.boot = wb_dat_i[23:16];
            end else begin
              ev[FWP_EV_REFUSED] = 1'b1;
            end
          end
          if (write_enable_activate) begin
            nxt_st.we = 1'b0;
          end
        end else if (write_enable_activate) begin
          nxt_st.we = 1'b0;
        end
      end
      nxt_st.key_clr = 1'b1;
      nxt_st.key = 8'h00;
    end
    // Serial record execution
    if (rec_i.valid) begin
      nxt_st.tx_v = 1'b1;
      ev[FWP_EV_REC] = 1'b1;
      if (!rec_i.sum_ok) begin
        nxt_st.tx_c = FWP_CH_BAD;
        ev[FWP_EV_BADSUM] = 1'b1;
      end else begin
        nxt_st.tx_c = FWP_CH_GOOD;
        if (write_enable_activate) begin
          nxt_st.we = 1'b1;
        end
        // Address field is not an input here at all
        unique case (rec_i.rtype)
          FWP_REC_SECT_CRC: begin
            nxt_st.crc_req = 1'b1;
            nxt_st.crc_glob = 1'b0;
            nxt_st.crc_sect = rec_i.d0;
          end
          FWP_REC_GLOB_CRC: begin
            nxt_st.crc_req = 1'b1;
            nxt_st.crc_glob = 1'b1;
          end
          FWP_REC_BAUD: begin
            nxt_st.baud = {rec_i.d0, rec_i.d1};
          end
          FWP_REC_RESET: begin
            nxt_st.rst_req = 1'b1;
          end
          FWP_REC_MWRITE: begin
            if (rec_i.d0 == FWP_SUB_CCP) begin
              if (ccp_ok) begin
                nxt_st.boot[FWP_BIT_CWP] = 1'b0;
              end else begin
                ev[FWP_EV_REFUSED] = 1'b1;
              end
            end else if (rec_i.d0 == FWP_SUB_STATUS) begin
              if (we_eff && !config_write_protect) begin
                nxt_st.boot = rec_i.d1;
              end else begin
                ev[FWP_EV_REFUSED] = 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
    // Read data
    nxt_st.dat = 32'h0000_0000;
    if (rd) begin
      unique case (wb_adr_i)
        FWP_A_CMD: nxt_st.dat = {24'h00_0000, st_ff.cmd};
        FWP_A_STAT: nxt_st.dat = {28'h000_0000, prot, config_write_protect, write_enable_activate, we_eff};
        FWP_A_IRQ_ST: nxt_st.dat = {28'h000_0000, st_ff.ist};
        FWP_A_IRQ_MSK: nxt_st.dat = {28'h000_0000, st_ff.imsk};
        FWP_A_BAUD: nxt_st.dat = {16'h0000, st_ff.baud};
        FWP_A_IAP: nxt_st.dat = {st_ff.key, st_ff.iap_data, st_ff.iap_arg,
          st_ff.iap_func};
        FWP_A_BOOT: nxt_st.dat = {24'h00_0000, st_ff.boot};
        default: nxt_st.dat = 32'h0000_0000;
      endcase
    end
    // Interrupt status: set wins over write-one-to-clear
    if (wr && wb_adr_i == FWP_A_IRQ_ST) begin
      nxt_st.ist = st_ff.ist & ~wb_dat_i[3:0];
    end
    if (wr && wb_adr_i == FWP_A_IRQ_MSK) begin
      nxt_st.imsk = wb_dat_i[3:0];
    end
    nxt_st.ist = nxt_st.ist | ev;
    nxt_st.irq = |(nxt_st.ist & nxt_st.imsk);
    nxt_st.fw_ok = !prot_mode(mode_i) || !nxt_st.boot[FWP_BIT_AWE] || nxt_st.we;
    nxt_st.cw_ok = !prot_mode(mode_i)
      || ((!nxt_st.boot[FWP_BIT_AWE] || nxt_st.we) && !nxt_st.boot[FWP_BIT_CWP]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.boot <= FWP_RST_BOOT;
      st_ff.baud <= FWP_RST_BAUD;
      st_ff.we <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    wb_dat_o = st_ff.dat;
    wb_ack_o = st_ff.ack;
    tx_valid_o = st_ff.tx_v;
    tx_char_o = st_ff.tx_c;
    mcu_reset_o = st_ff.rst_req;
    crc_req_o = st_ff.crc_req;
    crc_global_o = st_ff.crc_glob;
    crc_sector_o = st_ff.crc_sect;
    baud_o = st_ff.baud;
    we_flag_o = st_ff.we;
    flash_write_ok_o = st_ff.fw_ok;
    cfg_write_ok_o = st_ff.cw_ok;
    key_clear_o = st_ff.key_clr;
    irq_o = st_ff.irq;
  end
endmodule

// ---- bench/fwp_props.sv ----
// Port-level assertions for the flash protection block
`timescale 1ns/1ps
module fwp_props
  import fwp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire fwp_rec_t rec_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_char_o,
  input wire logic mcu_reset_o,
  input wire logic crc_req_o,
  input wire logic [7:0] crc_sector_o,
  input wire logic [15:0] baud_o,
  input wire logic key_clear_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ok;
  assign ok = rec_i.valid && rec_i.sum_ok;
  ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
  tx_reply_a: assert property (rec_i.valid |=> tx_valid_o &&
    tx_char_o == ($past(rec_i.sum_ok) ? FWP_CH_GOOD : FWP_CH_BAD)) else $error("bad reply");
  tx_cause_a: assert property (tx_valid_o |-> $past(rec_i.valid))
    else $error("stray reply");
  baud_load_a: assert property (ok && rec_i.rtype == FWP_REC_BAUD |=>
    baud_o == {$past(rec_i.d0), $past(rec_i.d1)}) else $error("bad baud");
  sect_crc_a: assert property (ok && rec_i.rtype == FWP_REC_SECT_CRC |=>
    crc_req_o && crc_sector_o == $past(rec_i.d0)) else $error("bad sector crc");
  rec_reset_a: assert property (ok && rec_i.rtype == FWP_REC_RESET |=> mcu_reset_o)
    else $error("no reset");
  bad_sum_a: assert property (rec_i.valid && !rec_i.sum_ok |=> !crc_req_o && !mcu_reset_o)
    else $error("bad record ran");
  key_clear_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
    wb_adr_i == FWP_A_IAP |-> ##[1:3] key_clear_o) else $error("key kept");
endmodule

// ---- bench/fwp_host.sv ----
// Host programmer model handing over received records
`timescale 1ns/1ps
module fwp_host
  import fwp_pkg::*;
(
  input wire logic clk_i,
  output fwp_rec_t rec_o
);
  initial rec_o = '0;
  // Address field never reaches the block; idle fields carry junk
  task automatic send(input logic [7:0] t, input logic [7:0] a, input logic [7:0] b,
    input logic ok);
    rec_o <= {1'h1, t, a, b, 8'($urandom), ok};
    @(posedge clk_i);
    rec_o <= {1'h0, ~t, ~a, ~b, 8'($urandom), ~ok};
    repeat ($urandom_range(4, 2)) @(posedge clk_i);
  endtask
endmodule

// ---- bench/fwp_top_tb.sv ----
// Self-checking bench for the flash protection block
`timescale 1ns/1ps
module fwp_top_tb
  import fwp_pkg::*;
;
  logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00, a, b;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [1:0] mode_i = 2'h0;
  logic [15:0] sect_crc_i = 16'h0, glob_crc_i = 16'h0, baud_o;
  fwp_rec_t rec_i;
  logic wb_ack_o, tx_valid_o, mcu_reset_o, crc_req_o, crc_global_o, we_flag_o;
  logic flash_write_ok_o, cfg_write_ok_o, key_clear_o, irq_o;
  logic [7:0] tx_char_o, crc_sector_o;
  int mismatches = 0, checked = 0, resets = 0, r;
  fwp_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_i, .rec_i, .sect_crc_i, .glob_crc_i,
    .tx_valid_o, .tx_char_o, .mcu_reset_o, .crc_req_o, .crc_global_o, .crc_sector_o,
    .baud_o, .we_flag_o, .flash_write_ok_o, .cfg_write_ok_o, .key_clear_o, .irq_o);
  fwp_host host_u (.clk_i, .rec_o(rec_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (mcu_reset_o === 1'h1) resets <= resets + 1;
  end
  function automatic logic [15:0] baud_of(logic [7:0] h, logic [7:0] l);
    return {h, l};
  endfunction
  task automatic wb(input logic w, input logic [7:0] adr, input logic [31:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    tally_and_finish;
  end
  initial begin
    r = $urandom(3806);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    sect_crc_i <= 16'($urandom);
    glob_crc_i <= 16'($urandom);
    @(posedge clk_i);
    wb(1'h0, FWP_A_BOOT, 32'h0);
    chk(q, 32'(FWP_RST_BOOT));
    wb(1'h0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk(flash_write_ok_o, 1'h1);
    chk(we_flag_o, 1'h0);
    host_u.send(FWP_REC_BAUD, 8'h12, 8'h34, 1'h0);
    chk(baud_o, FWP_RST_BAUD);
    chk(irq_o, 1'h0);
    wb(1'h1, FWP_A_IRQ_MSK, 32'h3);
    chk(irq_o, 1'h1);
    wb(1'h1, FWP_A_IRQ_ST, 32'hf);
    chk(irq_o, 1'h0);
    repeat (4) begin
      a = 8'($urandom);
      b = 8'($urandom);
      host_u.send(FWP_REC_BAUD, a, b, 1'h1);
      chk(baud_o, baud_of(a, b));
    end
    for (int t = 5; t <= 8; t++) begin
      host_u.send(8'(t), 8'($urandom), 8'h00, 1'h1);
    end
    chk(resets, 1);
    wb(1'h1, FWP_A_IAP, 32'h0);
    chk(resets, 2);
    wb(1'h1, FWP_A_IAP, {FWP_KEY, 24'h0});
    chk(resets, 2);
    wb(1'h1, FWP_A_BOOT, 32'h40);
    chk(cfg_write_ok_o, 1'h0);
    mode_i <= FWP_M_ICP;
    repeat (3) @(posedge clk_i);
    chk(cfg_write_ok_o, 1'h1);
    mode_i <= FWP_M_ISP;
    host_u.send(FWP_REC_MWRITE, FWP_SUB_CCP, 8'h00, 1'h1);
    chk(cfg_write_ok_o, 1'h1);
    wb(1'h1, FWP_A_BOOT, 32'h80);
    chk(flash_write_ok_o, 1'h0);
    wb(1'h1, FWP_A_CMD, 32'(FWP_CMD_SET_WE));
    wb(1'h1, FWP_A_DATA, 32'h55);
    chk(we_flag_o, 1'h0);
    wb(1'h1, FWP_A_CMD, 32'(FWP_CMD_SET_WE));
    wb(1'h1, FWP_A_DATA, 32'(FWP_KEY));
    chk(flash_write_ok_o, 1'h1);
    wb(1'h1, FWP_A_CMD, 32'(FWP_CMD_CLR_WE));
    wb(1'h1, FWP_A_DATA, 32'(FWP_KEY));
    chk(we_flag_o, 1'h0);
    host_u.send(FWP_REC_GLOB_CRC, 8'h00, 8'h00, 1'h1);
    chk(we_flag_o, 1'h1);
    chk(crc_global_o, 1'h1);
    wb(1'h1, FWP_A_IAP, {FWP_KEY, 16'h0, 8'h02});
    chk(we_flag_o, 1'h0);
    // Protect and disable-clear both set, then try to clear from serial
    host_u.send(FWP_REC_GLOB_CRC, 8'h00, 8'h00, 1'h1);
    wb(1'h1, FWP_A_BOOT, 32'hc0);
    host_u.send(FWP_REC_MWRITE, FWP_SUB_CCP, 8'h00, 1'h1);
    chk(cfg_write_ok_o, 1'h0);
    mode_i <= FWP_M_ICP;
    @(posedge clk_i);
    wb(1'h1, FWP_A_IAP, {FWP_KEY, 8'h00, FWP_SUB_CCP, FWP_REC_MWRITE});
    wb(1'h0, FWP_A_BOOT, 32'h0);
    chk(q, 32'h0);
    tally_and_finish;
  end
endmodule
bind fwp_top fwp_props chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_ack_o, .rec_i, .tx_valid_o, .tx_char_o, .mcu_reset_o, .crc_req_o, .crc_sector_o,
  .baud_o, .key_clear_o);
